// file: verilog/rops_consts.vh
// Constants for the remap output pin select block (pins 10..17).
// Assumes inclusion by the single design file; definitions only.
`ifndef ROPS_CONSTS_VH
`define ROPS_CONSTS_VH

// Register indices; byte address is four times the index
`define ROPS_IDX_PINS_10_11  2'h0
`define ROPS_IDX_PINS_12_13  2'h1
`define ROPS_IDX_PINS_14_15  2'h2
`define ROPS_IDX_PINS_16_17  2'h3

// Field layout inside each 16-bit selector register
`define ROPS_EVEN_LSB        0
`define ROPS_EVEN_MSB        5
`define ROPS_ODD_LSB         8
`define ROPS_ODD_MSB         13
`define ROPS_IMPL_MASK       16'h3F3F
`define ROPS_SEL_RESET       6'h00

// Bus answer values
`define ROPS_UNMAPPED_RDATA  32'h00000000

`endif

// file: verilog/rops_remap_output_pin_select.v
// Output-side remappable pin selector for pins 10..17, Avalon-MM slave.
// Assumes a 10 MHz mclk_in, synchronous active-high reset, and a word-addressed
// byte address on the bus; peripheral output function numbering lives elsewhere.
//
// Operation
// - Each pin has 6-bit selector, resets zero
// - Odd pin bits 13:8, even 5:0
// - Bits 15:14 and 7:6 read zero
// - Pin 15 selector absent in smallest package
module rops_remap_output_pin_select #(
  parameter SEL_W       = 6,
  parameter SMALL_PKG   = 0,
  parameter ADDR_W      = 4
) (
  input  wire                mclk_in,
  input  wire                sys_rst_in,
  input  wire [ADDR_W-1:0]   avs_address_in,
  input  wire                avs_read_in,
  input  wire                avs_write_in,
  input  wire [31:0]         avs_writedata_in,
  input  wire [3:0]          avs_byteenable_in,
  output reg  [31:0]         avs_readdata_out,
  output reg                 avs_waitrequest_out,
  output reg  [SEL_W-1:0]    out_sel_pin10_out,
  output reg  [SEL_W-1:0]    out_sel_pin11_out,
  output reg  [SEL_W-1:0]    out_sel_pin12_out,
  output reg  [SEL_W-1:0]    out_sel_pin13_out,
  output reg  [SEL_W-1:0]    out_sel_pin14_out,
  output reg  [SEL_W-1:0]    out_sel_pin15_out,
  output reg  [SEL_W-1:0]    out_sel_pin16_out,
  output reg  [SEL_W-1:0]    out_sel_pin17_out
);
`include "rops_consts.vh"

  // One-hot bus states
  localparam ST_IDLE = 2'b01;
  localparam ST_ACK  = 2'b10;

  // Bus handshake registers
  reg  [1:0]        state_ff;
  reg  [1:0]        nxt_state;
  reg               nxt_wait;
  reg  [31:0]       nxt_rdata;

  // Next values of the eight selectors
  reg  [SEL_W-1:0]  nxt_sel_pin10;
  reg  [SEL_W-1:0]  nxt_sel_pin11;
  reg  [SEL_W-1:0]  nxt_sel_pin12;
  reg  [SEL_W-1:0]  nxt_sel_pin13;
  reg  [SEL_W-1:0]  nxt_sel_pin14;
  reg  [SEL_W-1:0]  nxt_sel_pin15;
  reg  [SEL_W-1:0]  nxt_sel_pin16;
  reg  [SEL_W-1:0]  nxt_sel_pin17;

  // Register image chosen for a read
  reg  [15:0]       rd_image;

  // Address decode
  wire [ADDR_W-1:0] addr_hi;
  wire              word_ok;
  wire              mapped;
  wire [1:0]        reg_idx;
  wire              req;

  // Register selects
  wire              hit_10_11;
  wire              hit_12_13;
  wire              hit_14_15;
  wire              hit_16_17;

  // Write strobes, one per selector field
  wire              wr_accept;
  wire              lane_even;
  wire              lane_odd;
  wire              wr_pin10;
  wire              wr_pin11;
  wire              wr_pin12;
  wire              wr_pin13;
  wire              wr_pin14;
  wire              wr_pin15;
  wire              wr_pin16;
  wire              wr_pin17;

  // Write data lanes
  wire [7:0]        wd_even;
  wire [7:0]        wd_odd;

  // Register images as software reads them
  wire [15:0]       img_10_11;
  wire [15:0]       img_12_13;
  wire [15:0]       img_14_15;
  wire [15:0]       img_16_17;

  // Merge one byte lane of new data into a 6-bit field
  function [SEL_W-1:0] merge;
    input [SEL_W-1:0] old;
    input [7:0]       data;
    input             en;
    begin
      merge = en ? data[SEL_W-1:0] : old;
    end
  endfunction

  // Assemble one 16-bit register image; reserved bits stay zero
  function [15:0] pack;
    input [SEL_W-1:0] even;
    input [SEL_W-1:0] odd;
    begin
      pack = 16'h0000;
      pack[`ROPS_EVEN_MSB:`ROPS_EVEN_LSB] = even;
      pack[`ROPS_ODD_MSB:`ROPS_ODD_LSB]   = odd;
      pack = pack & `ROPS_IMPL_MASK;
    end
  endfunction

  // Word index compare, shared by the four register selects
  function is_reg;
    input [1:0] idx;
    input [1:0] want;
    begin
      is_reg = (idx == want);
    end
  endfunction

  // Upper address bits must be zero; the shift keeps the width for any ADDR_W
  assign addr_hi = avs_address_in >> 4;
  // Byte addresses off a word boundary are unmapped rather than aliased
  assign word_ok = (avs_address_in[1:0] == 2'b00);
  assign mapped  = word_ok && (addr_hi == {ADDR_W{1'b0}});
  assign reg_idx = avs_address_in[3:2];
  assign req     = avs_read_in | avs_write_in;

  assign hit_10_11 = mapped && is_reg(reg_idx, `ROPS_IDX_PINS_10_11);
  assign hit_12_13 = mapped && is_reg(reg_idx, `ROPS_IDX_PINS_12_13);
  assign hit_14_15 = mapped && is_reg(reg_idx, `ROPS_IDX_PINS_14_15);
  assign hit_16_17 = mapped && is_reg(reg_idx, `ROPS_IDX_PINS_16_17);

  // Writes land only at the edge where waitrequest is low, the one edge
  // at which the master counts the transfer as done
  assign wr_accept = (state_ff == ST_ACK) && avs_write_in;
  assign lane_even = wr_accept && avs_byteenable_in[0];
  assign lane_odd  = wr_accept && avs_byteenable_in[1];

  // Lanes 2 and 3 carry no selector and are dropped
  assign wd_even = avs_writedata_in[7:0];
  assign wd_odd  = avs_writedata_in[15:8];

  assign wr_pin10 = lane_even && hit_10_11;
  assign wr_pin11 = lane_odd  && hit_10_11;
  assign wr_pin12 = lane_even && hit_12_13;
  assign wr_pin13 = lane_odd  && hit_12_13;
  assign wr_pin14 = lane_even && hit_14_15;
  assign wr_pin15 = lane_odd  && hit_14_15;
  assign wr_pin16 = lane_even && hit_16_17;
  assign wr_pin17 = lane_odd  && hit_16_17;

  assign img_10_11 = pack(out_sel_pin10_out, out_sel_pin11_out);
  assign img_12_13 = pack(out_sel_pin12_out, out_sel_pin13_out);
  assign img_14_15 = pack(out_sel_pin14_out, out_sel_pin15_out);
  assign img_16_17 = pack(out_sel_pin16_out, out_sel_pin17_out);

  // Selector next values; a field not written keeps its value
  always @* begin
    nxt_sel_pin10 = merge(out_sel_pin10_out, wd_even, wr_pin10);
    nxt_sel_pin11 = merge(out_sel_pin11_out, wd_odd,  wr_pin11);
    nxt_sel_pin12 = merge(out_sel_pin12_out, wd_even, wr_pin12);
    nxt_sel_pin13 = merge(out_sel_pin13_out, wd_odd,  wr_pin13);
    nxt_sel_pin14 = merge(out_sel_pin14_out, wd_even, wr_pin14);
    nxt_sel_pin15 = merge(out_sel_pin15_out, wd_odd,  wr_pin15);
    nxt_sel_pin16 = merge(out_sel_pin16_out, wd_even, wr_pin16);
    nxt_sel_pin17 = merge(out_sel_pin17_out, wd_odd,  wr_pin17);
    if (SMALL_PKG != 0) begin
      // Small package has no pin 15 field; nothing can ever set it
      nxt_sel_pin15 = `ROPS_SEL_RESET;
    end
  end

  // Selector flip-flops drive the pins directly
  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      out_sel_pin10_out <= `ROPS_SEL_RESET;
    end else begin
      out_sel_pin10_out <= nxt_sel_pin10;
    end
  end

  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      out_sel_pin11_out <= `ROPS_SEL_RESET;
    end else begin
      out_sel_pin11_out <= nxt_sel_pin11;
    end
  end

  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      out_sel_pin12_out <= `ROPS_SEL_RESET;
    end else begin
      out_sel_pin12_out <= nxt_sel_pin12;
    end
  end

  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      out_sel_pin13_out <= `ROPS_SEL_RESET;
    end else begin
      out_sel_pin13_out <= nxt_sel_pin13;
    end
  end

  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      out_sel_pin14_out <= `ROPS_SEL_RESET;
    end else begin
      out_sel_pin14_out <= nxt_sel_pin14;
    end
  end

  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      out_sel_pin15_out <= `ROPS_SEL_RESET;
    end else begin
      out_sel_pin15_out <= nxt_sel_pin15;
    end
  end

  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      out_sel_pin16_out <= `ROPS_SEL_RESET;
    end else begin
      out_sel_pin16_out <= nxt_sel_pin16;
    end
  end

  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      out_sel_pin17_out <= `ROPS_SEL_RESET;
    end else begin
      out_sel_pin17_out <= nxt_sel_pin17;
    end
  end

  // Read image of the addressed register; unmapped addresses read zero
  always @* begin
    rd_image = 16'h0000;
    if (mapped) begin
      case (reg_idx)
        `ROPS_IDX_PINS_10_11: rd_image = img_10_11;
        `ROPS_IDX_PINS_12_13: rd_image = img_12_13;
        `ROPS_IDX_PINS_14_15: rd_image = img_14_15;
        `ROPS_IDX_PINS_16_17: rd_image = img_16_17;
        default:              rd_image = 16'h0000;
      endcase
    end
  end

  // Bus handshake: take in idle, answer one cycle later, then back to idle
  always @* begin
    nxt_state = ST_IDLE;
    nxt_wait  = 1'b1;
    case (state_ff)
      ST_IDLE: begin
        if (req) begin
          nxt_state = ST_ACK;
          nxt_wait  = 1'b0;
        end
      end
      ST_ACK: begin
        // Master releases the request at this edge; no second answer
        nxt_state = ST_IDLE;
        nxt_wait  = 1'b1;
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_wait  = 1'b1;
      end
    endcase
  end

  // Read data loads at the take edge and holds until the next answer
  always @* begin
    nxt_rdata = avs_readdata_out;
    if ((state_ff == ST_IDLE) && req) begin
      nxt_rdata = `ROPS_UNMAPPED_RDATA;
      if (avs_read_in) begin
        nxt_rdata = {16'h0000, rd_image};
      end
    end
  end

  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Waitrequest stays high in reset so no request is taken early
  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      avs_waitrequest_out <= 1'b1;
    end else begin
      avs_waitrequest_out <= nxt_wait;
    end
  end

  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      avs_readdata_out <= 32'h00000000;
    end else begin
      avs_readdata_out <= nxt_rdata;
    end
  end

endmodule // rops_remap_output_pin_select

// file: testbench/rops_remap_output_pin_select_sva.sv
// Checker for the selector block's bus and pin ports.
// Assumes one clock, synchronous active-high reset.
module rops_checker (
  input logic        mclk_in,
  input logic        sys_rst_in,
  input logic [3:0]  avs_address_in,
  input logic        avs_read_in,
  input logic        avs_write_in,
  input logic [31:0] avs_writedata_in,
  input logic [3:0]  avs_byteenable_in,
  input logic [31:0] avs_readdata_out,
  input logic        avs_waitrequest_out,
  input logic [5:0]  out_sel_pin10_out,
  input logic [5:0]  out_sel_pin12_out,
  input logic [5:0]  out_sel_pin13_out,
  input logic [5:0]  out_sel_pin17_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  a_ack_one_cycle: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out ##1 avs_waitrequest_out) else $error("ack not one cycle");
  a_even_write: assert property (avs_write_in && !avs_waitrequest_out && avs_address_in == 4'h0
    && avs_byteenable_in[0] |=> out_sel_pin10_out == $past(avs_writedata_in[5:0])) else $error("pin10 bad");
  a_odd_write: assert property (avs_write_in && !avs_waitrequest_out && avs_address_in == 4'hC
    && avs_byteenable_in[1] |=> out_sel_pin17_out == $past(avs_writedata_in[13:8])) else $error("pin17 bad");
  a_even_read: assert property (avs_read_in && avs_waitrequest_out && avs_address_in == 4'h4
    |=> avs_readdata_out[5:0] == $past(out_sel_pin12_out)) else $error("read bad");
  a_read_zeros: assert property (!avs_waitrequest_out
    |-> avs_readdata_out[31:14] == 0 && avs_readdata_out[7:6] == 0) else $error("bits not zero");
  a_odd_hold: assert property (!avs_write_in || avs_address_in != 4'h4
    |=> $stable(out_sel_pin13_out)) else $error("pin13 moved");
endmodule // rops_checker

bind rops_remap_output_pin_select rops_checker rops_checker_i (.mclk_in, .sys_rst_in, .avs_address_in,
  .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
  .out_sel_pin10_out, .out_sel_pin12_out, .out_sel_pin13_out, .out_sel_pin17_out);

// file: testbench/rops_remap_output_pin_select_test.sv
// Bench for the selector block, small and full package variants side by side.
// Assumes the block answers every bus request; both copies share one bus.
module rops_remap_output_pin_select_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk_in = 0, sys_rst_in = 1, rd = 0, wr = 0, wreq, wreq_f;
  logic [3:0]  addr = 0, be = 0;
  logic [31:0] wd = 0, rdata, rdata_f;
  logic [15:0] e, m;
  logic [5:0]  p [8];
  logic [5:0]  q [8];
  int          fails = 0, checks = 0, cyc = 0;
  always #50 mclk_in = ~mclk_in;
  rops_remap_output_pin_select #(.SMALL_PKG(1)) rops_remap_output_pin_select_i (.mclk_in, .sys_rst_in,
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .out_sel_pin10_out(p[0]), .out_sel_pin11_out(p[1]),
    .out_sel_pin12_out(p[2]), .out_sel_pin13_out(p[3]), .out_sel_pin14_out(p[4]), .out_sel_pin15_out(p[5]),
    .out_sel_pin16_out(p[6]), .out_sel_pin17_out(p[7]));
  // Full package copy on the same bus, to cover the pin 15 field
  rops_remap_output_pin_select #(.SMALL_PKG(0)) rops_remap_output_pin_select_full_i (.mclk_in, .sys_rst_in,
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be),
    .avs_readdata_out(rdata_f), .avs_waitrequest_out(wreq_f), .out_sel_pin10_out(q[0]), .out_sel_pin11_out(q[1]),
    .out_sel_pin12_out(q[2]), .out_sel_pin13_out(q[3]), .out_sel_pin14_out(q[4]), .out_sel_pin15_out(q[5]),
    .out_sel_pin16_out(q[6]), .out_sel_pin17_out(q[7]));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge mclk_in);
    wr <= w; rd <= !w; addr <= a; wd <= d; be <= b;
    do @(posedge mclk_in); while (wreq !== 1'b0);
    wr <= 0; rd <= 0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] exp_f);
    xfer(0, a, 0, 0);
    chk(rdata, exp);
    chk(rdata_f, exp_f);
    chk(wreq_f, 0);
  endtask
  // Pins move at the ack edge; look once they have settled
  task automatic chk_pin(input int k, input logic [11:0] exp_s, input logic [11:0] exp_f);
    @(negedge mclk_in);
    chk({p[2*k+1], p[2*k]}, exp_s);
    chk({q[2*k+1], q[2*k]}, exp_f);
  endtask
  task stop_test;
    $display("fails=%0d checks=%0d", fails, checks);
    if (fails == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Whole run needs well under 300 cycles
  always @(posedge mclk_in) if (++cyc == 1000) begin
    fails++;
    stop_test;
  end
  initial begin
    repeat (6) @(posedge mclk_in);
    sys_rst_in <= 0;
    for (int i = 0; i < 4; i++) rdc(4'(4*i), 0, 0);
    for (int i = 0; i < 4; i++) begin
      m = (i == 2) ? 16'h003F : 16'h3F3F;
      e = {2'b10, 6'(i*9+1), 2'b01, 6'(i*7+2)};
      xfer(1, 4'(4*i), 32'hFFFFFFFF, 4'hF);
      rdc(4'(4*i), {16'h0, m}, 32'h00003F3F);
      xfer(1, 4'(4*i), {16'hFFFF, e}, 4'h1);
      chk_pin(i, {m[13:8], e[5:0]}, {6'h3F, e[5:0]});
      xfer(1, 4'(4*i), {16'h0, e}, 4'h2);
      rdc(4'(4*i), {16'h0, e & m}, {16'h0, e & 16'h3F3F});
      chk_pin(i, {e[13:8] & m[13:8], e[5:0]}, {e[13:8], e[5:0]});
    end
    xfer(1, 4'h2, 32'h0, 4'hF);
    rdc(4'h2, 0, 0);
    rdc(4'h0, 32'h0102, 32'h0102);
    stop_test;
  end
endmodule // rops_remap_output_pin_select_test
